/* dv/core_exception_integration_tb.sv */
// Register-level testbench for the exception integration block
`timescale 1ns/1ns
module core_exception_integration_tb;
  import exc_pkg::*;
  logic              clk_sys_in;
  logic              rst_b_in;
  reg_req_t          req;
  core_evt_t         evt_r;
  logic [31:0]       rdata_out;
  logic [59:0]       irq;
  logic [59:0]       fire;
  logic [59:0]       pend;
  logic [7:0]        rst_len;
  logic              sleep_o;
  logic              sysrst_o;
  logic              ev_o;
  logic              excl_o;
  logic [3:0]        lit_o;
  logic [3:0]        insn_o;
  logic              prot_o;
  logic              wake_o;
  int                n_errors;
  int                tests_run;

  core_exception_integration uut (
    .clk_sys_in                   (clk_sys_in),
    .rst_b_in                     (rst_b_in),
    .req_in                       (req),
    .rdata_out                    (rdata_out),
    .irq_in                       (irq),
    .core_evt_in                  (evt_r),
    .irq_pend_out                 (pend),
    .sleep_indication_out         (sleep_o),
    .sys_reset_request_out        (sysrst_o),
    .event_in_out                 (ev_o),
    .excl_okay_out                (excl_o),
    .lit_comp_count_out           (lit_o),
    .insn_comp_count_out          (insn_o),
    .mem_protect_unit_present_out (prot_o),
    .wakeup_irq_ctrl_present_out  (wake_o)
  );

  irq_src_model #(.N(60)) far (
    .clk_sys_in           (clk_sys_in),
    .rst_b_in             (rst_b_in),
    .fire_in              (fire),
    .sys_reset_request_in (sysrst_o),
    .irq_out              (irq),
    .reset_len_out        (rst_len)
  );

  initial
  begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk_sys_in);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_in);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk_sys_in);
    req.rd <= 1'b0;
    #1;
    chk(rdata_out, exp);
  endtask

  task automatic evt(input logic [4:0] e);
    @(posedge clk_sys_in);
    evt_r <= core_evt_t'(e);
    @(posedge clk_sys_in);
    evt_r <= core_evt_t'(5'h00);
  endtask

  task automatic fire_irq(input logic [59:0] m);
    @(posedge clk_sys_in);
    fire <= m;
    @(posedge clk_sys_in);
    fire <= '0;
    repeat (2) @(posedge clk_sys_in);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    n_errors  = 0;
    tests_run = 0;
    rst_b_in  = 1'b0;
    req       = '0;
    evt_r     = '0;
    fire      = '0;
    repeat (16) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    #1;
    chk({pend[31:0]}, 32'h0000_0000);
    chk(32'({sleep_o, sysrst_o}), 32'h0000_0000);
    rchk(OFS_CTRL_TYPE, 32'h0000_0000);
    rchk(OFS_AUX_FAULT, 32'h0000_0000);
    wr(OFS_AUX_FAULT, 32'hFFFF_FFFF);
    rchk(OFS_AUX_FAULT, 32'h0000_0000);
    rchk(OFS_CONFIG, 32'h0000_0062);
    chk(32'({lit_o, insn_o, prot_o, wake_o, ev_o, excl_o}), 32'h0000_0260);
    wr(8'h40, 32'hFFFF_FFFF);
    rchk(8'h40, 32'h0000_0000);
    // Priority fields keep only the top three bits
    wr(OFS_PRIO_SEL, 32'h0000_003B);
    wr(OFS_PRIO_DATA, 32'h0000_00FF);
    wr(OFS_PRIO_SEL, 32'h0000_0000);
    wr(OFS_PRIO_DATA, 32'h0000_001F);
    rchk(OFS_PRIO_DATA, 32'h0000_0000);
    wr(OFS_PRIO_SEL, 32'h0000_003B);
    rchk(OFS_PRIO_DATA, 32'h0000_00E0);
    wr(OFS_PRIO_SEL, 32'h0000_003C);
    rchk(OFS_PRIO_DATA, 32'h0000_0000);
    // Lowest and highest interrupt lines
    fire_irq({1'b1, 58'h0, 1'b1});
    rchk(OFS_PEND_LO, 32'h0000_0001);
    rchk(OFS_PEND_HI, 32'h0800_0000);
    chk(pend[59:28], 32'h8000_0000);
    wr(OFS_PEND_LO, 32'h0000_0001);
    wr(OFS_PEND_HI, 32'h0800_0000);
    rchk(OFS_PEND_HI, 32'h0000_0000);
    // Deep-sleep bit stored but has no effect on sleep
    wr(OFS_SYS_CTRL, 32'h0000_0004);
    evt(5'h10);
    rchk(OFS_STATUS, 32'h0000_0001);
    chk(32'(sleep_o), 32'h0000_0001);
    fire_irq(60'h1);
    rchk(OFS_STATUS, 32'h0000_0000);
    evt(5'h08);
    rchk(OFS_STATUS, 32'h0000_0000);
    wr(OFS_SYS_CTRL, 32'h0000_0002);
    evt(5'h08);
    rchk(OFS_STATUS, 32'h0000_0001);
    evt(5'h04);
    rchk(OFS_STATUS, 32'h0000_0000);
    evt(5'h01);
    rchk(OFS_STATUS, 32'h0000_0000);
    chk(32'({ev_o, excl_o}), 32'h0000_0000);
    // Core_flag_a ignores sleep requests and interrupts
    evt(5'h02);
    rchk(OFS_STATUS, 32'h0000_0002);
    evt(5'h10);
    fire_irq(60'h2);
    rchk(OFS_STATUS, 32'h0000_0002);
    evt(5'h04);
    rchk(OFS_STATUS, 32'h0000_0000);
    wr(OFS_RESET_CTRL, 32'h0000_0004);
    repeat (8) @(posedge clk_sys_in);
    #1;
    chk(32'(rst_len), 32'h0000_0004);
    chk(32'(sysrst_o), 32'h0000_0000);
    give_verdict();
  end
endmodule

/* dv/irq_src_model.sv */
// Far-side model: peripheral interrupt sources and system reset logic
`timescale 1ns/1ns
module irq_src_model #(
  parameter int unsigned N = 60
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_b_in,
  input  wire logic [N-1:0] fire_in,
  input  wire logic         sys_reset_request_in,
  output logic      [N-1:0] irq_out,
  output logic      [7:0]   reset_len_out
);
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      irq_out       <= '0;
      reset_len_out <= 8'h00;
    end
    else
    begin
      irq_out <= fire_in;
      // reset request length
      // Counts total high cycles, so one request per run only
      if (sys_reset_request_in)
        reset_len_out <= reset_len_out + 8'h01;
    end
  end
endmodule

/* hw/core_exception_integration.sv */
// Exception and system-signal integration of the processor core
// What this block does
// - Sixty peripheral interrupt request lines reach the interrupt controller.
// - Interrupt line count field, bits four to zero, reads zero.
// - Three priority bits per interrupt.
// - Setting the reset request bit raises a system reset.
// - Core_flag_a indication unused; only NMI or reset leaves core_flag_a.
// - Auxiliary fault status register always reads zero.
// - Event output unused, event input held inactive.
// - Sleep indication on wait-for-interrupt, or ISR exit with sleep-on-exit.
// - Deep-sleep indication ignored; deep-sleep bit kept cleared by software.
// - Data-side bus has no exclusive access monitor.
// - Two literal and six instruction comparators; no memory protection unit, no wakeup controller.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module core_exception_integration #(
  parameter int unsigned N_IRQ = exc_pkg::IRQ_COUNT
) (
  input  wire logic                clk_sys_in,
  input  wire logic                rst_b_in,
  input  wire exc_pkg::reg_req_t   req_in,
  output logic [31:0]              rdata_out,
  input  wire logic [N_IRQ-1:0]    irq_in,
  input  wire exc_pkg::core_evt_t  core_evt_in,
  output logic [N_IRQ-1:0]         irq_pend_out,
  output logic                     sleep_indication_out,
  output logic                     sys_reset_request_out,
  output logic                     event_in_out,
  output logic                     excl_okay_out,
  output logic [3:0]               lit_comp_count_out,
  output logic [3:0]               insn_comp_count_out,
  output logic                     mem_protect_unit_present_out,
  output logic                     wakeup_irq_ctrl_present_out
);
  import exc_pkg::*;

  logic [31:0]     rdata_reg;
  logic [31:0]     rdata_next;
  logic [N_IRQ-1:0] pend_reg;
  logic [N_IRQ-1:0] pend_next;
  logic            sleep_on_isr_exit_reg;
  logic            sleep_on_isr_exit_next;
  logic            deep_sleep_reg;
  logic            deep_sleep_next;
  logic [5:0]      prio_sel_reg;
  logic [5:0]      prio_sel_next;
  logic            sys_req_pulse;
  logic            sys_reset_hold;
  logic            prio_wr;
  logic [2:0]      prio_rd;
  core_state_t     state_reg;
  core_state_t     state_next;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  exc_prio_store #(
    .N (N_IRQ),
    .W (PRIO_BITS)
  ) u_prio (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .wr_in      (prio_wr),
    .idx_in     (prio_sel_reg),
    .wdata_in   (req_in.wdata[7:5]),
    .rd_idx_in  (prio_sel_reg),
    .rdata_out  (prio_rd)
  );

  exc_reset_gen #(
    .HOLD (RESET_HOLD)
  ) u_rst (
    .clk_sys_in    (clk_sys_in),
    .rst_b_in      (rst_b_in),
    .req_in        (sys_req_pulse),
    .sys_reset_out (sys_reset_hold)
  );

  assign prio_wr = req_in.wr && hit(req_in.addr, OFS_PRIO_DATA);
  assign sys_req_pulse = req_in.wr && hit(req_in.addr, OFS_RESET_CTRL)
                         && req_in.wdata[BIT_SYS_RESET];

  // Register writes and pending latches
  always_comb
  begin
    sleep_on_isr_exit_next = sleep_on_isr_exit_reg;
    deep_sleep_next        = deep_sleep_reg;
    prio_sel_next          = prio_sel_reg;
    pend_next              = pend_reg;
    if (req_in.wr)
    begin
      if (hit(req_in.addr, OFS_SYS_CTRL))
      begin
        sleep_on_isr_exit_next = req_in.wdata[BIT_SLEEP_EXIT];
        deep_sleep_next        = req_in.wdata[BIT_DEEP_SLEEP];
      end
      else if (hit(req_in.addr, OFS_PRIO_SEL))
      begin
        prio_sel_next = req_in.wdata[5:0];
      end
      else if (hit(req_in.addr, OFS_PEND_LO))
      begin
        pend_next[31:0] = pend_reg[31:0] & ~req_in.wdata;
      end
      else if (hit(req_in.addr, OFS_PEND_HI))
      begin
        pend_next[N_IRQ-1:32] = pend_reg[N_IRQ-1:32] & ~req_in.wdata[N_IRQ-33:0];
      end
    end
    // sixty lines latched, set beats clear
    pend_next = pend_next | irq_in;
  end

  // Read mux, answer one cycle after the strobe
  always_comb
  begin
    rdata_next = WORD_ZERO;
    if (req_in.rd)
    begin
      if (hit(req_in.addr, OFS_CTRL_TYPE))
      begin
        rdata_next[LINE_CNT_W-1:0] = LINE_CNT_VALUE;
      end
      else if (hit(req_in.addr, OFS_AUX_FAULT))
      begin
        rdata_next = AUX_FAULT_VALUE;
      end
      else if (hit(req_in.addr, OFS_SYS_CTRL))
      begin
        rdata_next[BIT_SLEEP_EXIT] = sleep_on_isr_exit_reg;
        rdata_next[BIT_DEEP_SLEEP] = deep_sleep_reg;
      end
      else if (hit(req_in.addr, OFS_CONFIG))
      begin
        rdata_next[3:0] = 4'(LIT_COMPARATORS);
        rdata_next[7:4] = 4'(INSN_COMPARATORS);
      end
      else if (hit(req_in.addr, OFS_STATUS))
      begin
        rdata_next[BIT_ST_SLEEP]  = (state_reg == ST_SLEEP);
        rdata_next[BIT_ST_LOCKED] = (state_reg == ST_LOCKED);
        rdata_next[BIT_ST_EXCL]   = 1'b0;
      end
      else if (hit(req_in.addr, OFS_PRIO_SEL))
      begin
        rdata_next[5:0] = prio_sel_reg;
      end
      else if (hit(req_in.addr, OFS_PRIO_DATA))
      begin
        rdata_next[7:0] = {prio_rd, 5'h00} & PRIO_MASK;
      end
      else if (hit(req_in.addr, OFS_PEND_LO))
      begin
        rdata_next = pend_reg[31:0];
      end
      else if (hit(req_in.addr, OFS_PEND_HI))
      begin
        rdata_next[N_IRQ-33:0] = pend_reg[N_IRQ-1:32];
      end
    end
  end

  // Core sleep and core_flag_a tracking
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
      begin
        if (core_evt_in.fault_unrecoverable)
        begin
          state_next = ST_LOCKED;
        end
        else if (core_evt_in.wait_interrupt_instr
                 || (core_evt_in.isr_exit && sleep_on_isr_exit_reg))
        begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if ((|irq_in) || core_evt_in.nmi)
        begin
          state_next = ST_RUN;
        end
      end
      ST_LOCKED:
      begin
        if (core_evt_in.nmi)
        begin
          state_next = ST_RUN;
        end
      end
      default:
      begin
        state_next = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      rdata_reg             <= WORD_ZERO;
      pend_reg              <= '0;
      sleep_on_isr_exit_reg <= 1'b0;
      deep_sleep_reg        <= 1'b0;
      prio_sel_reg          <= 6'h00;
      state_reg             <= ST_RUN;
    end
    else
    begin
      rdata_reg             <= rdata_next;
      pend_reg              <= pend_next;
      sleep_on_isr_exit_reg <= sleep_on_isr_exit_next;
      deep_sleep_reg        <= deep_sleep_next;
      prio_sel_reg          <= prio_sel_next;
      state_reg             <= state_next;
    end
  end

  assign rdata_out             = rdata_reg;
  assign irq_pend_out          = pend_reg;
  // deep-sleep bit stored but never steers anything
  assign sleep_indication_out  = (state_reg == ST_SLEEP);
  assign sys_reset_request_out = sys_reset_hold;
  assign event_in_out          = 1'b0;
  // no exclusive monitor, never reports success
  assign excl_okay_out         = 1'b0;
  assign lit_comp_count_out    = 4'(LIT_COMPARATORS);
  assign insn_comp_count_out   = 4'(INSN_COMPARATORS);
  assign mem_protect_unit_present_out = 1'b0;
  assign wakeup_irq_ctrl_present_out  = 1'b0;

  a_line_count_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    req_in.rd && req_in.addr == OFS_CTRL_TYPE |=> rdata_out[4:0] == 5'h00)
    else $error("line count not zero");
  a_aux_fault_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    req_in.rd && req_in.addr == OFS_AUX_FAULT |=> rdata_out == 32'h0000_0000)
    else $error("aux fault nonzero");
  a_reset_follows_req: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    sys_req_pulse |=> sys_reset_request_out [*4])
    else $error("reset request lost");
  a_irq_latched: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    irq_in[0] |=> irq_pend_out[0])
    else $error("irq not pended");
  a_lock_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state_reg == ST_LOCKED && !core_evt_in.nmi |=> state_reg == ST_LOCKED)
    else $error("core_flag_a left without nmi");
  a_sleep_on_wait: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state_reg == ST_RUN && core_evt_in.wait_interrupt_instr
    && !core_evt_in.fault_unrecoverable |=> sleep_indication_out)
    else $error("no sleep on wait for interrupt");
  a_event_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !event_in_out && !excl_okay_out)
    else $error("event or exclusive active");
  a_prio_low_zero: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    req_in.rd && req_in.addr == OFS_PRIO_DATA |=> rdata_out[4:0] == 5'h00)
    else $error("low priority bits set");
  c_reset_req: cover property (@(posedge clk_sys_in) sys_req_pulse);
  c_sleep: cover property (@(posedge clk_sys_in) $rose(sleep_indication_out));
  c_core_flag_a: cover property (@(posedge clk_sys_in) state_reg == ST_LOCKED);
  c_sleep_exit: cover property (@(posedge clk_sys_in)
    state_reg == ST_RUN && core_evt_in.isr_exit && sleep_on_isr_exit_reg);
  c_pend_top: cover property (@(posedge clk_sys_in) irq_pend_out[N_IRQ-1]);

  // Read data must fall back to zero so a stale word is never taken twice
  a_rdata_idle: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !req_in.rd |=> rdata_out == 32'h0000_0000)
    else $error("read data not idle");
  a_config_read: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    req_in.rd && req_in.addr == OFS_CONFIG |=> rdata_out[7:0] == 8'h62)
    else $error("comparator counts wrong");
  a_pend_clear: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    req_in.wr && req_in.addr == OFS_PEND_LO && req_in.wdata[0] && !irq_in[0] |=> !irq_pend_out[0])
    else $error("pending bit not cleared");
  a_reset_ends: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    sys_req_pulse ##1 !sys_req_pulse [*4] |=> !sys_reset_request_out)
    else $error("reset request too long");
  a_lock_entry: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state_reg == ST_RUN && core_evt_in.fault_unrecoverable |=> state_reg == ST_LOCKED)
    else $error("fault did not lock");
  a_sleep_on_exit: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state_reg == ST_RUN && core_evt_in.isr_exit && sleep_on_isr_exit_reg
    && !core_evt_in.fault_unrecoverable |=> sleep_indication_out)
    else $error("no sleep on routine exit");
  // Deep-sleep setting alone must never put the core to sleep
  a_run_stays: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state_reg == ST_RUN && !core_evt_in.wait_interrupt_instr && !core_evt_in.isr_exit
    && !core_evt_in.fault_unrecoverable |=> !sleep_indication_out)
    else $error("sleep without a cause");
  a_sleep_wake: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    state_reg == ST_SLEEP && (|irq_in) |=> !sleep_indication_out)
    else $error("interrupt did not wake");
endmodule

/* hw/exc_pkg.sv */
// Package: constants, register map and carriers for the exception integration block
package exc_pkg;
  localparam int unsigned IRQ_COUNT      = 60;
  localparam int unsigned PRIO_BITS      = 3;
  localparam int unsigned PRIO_FIELD_W   = 8;
  localparam int unsigned ADDR_W         = 8;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned IRQ_IDX_W      = 6;
  localparam int unsigned LIT_COMPARATORS  = 2;
  localparam int unsigned INSN_COMPARATORS = 6;
  localparam int unsigned RESET_HOLD       = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_TYPE  = 8'h00;
  localparam logic [7:0] OFS_AUX_FAULT  = 8'h04;
  localparam logic [7:0] OFS_RESET_CTRL = 8'h08;
  localparam logic [7:0] OFS_SYS_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_CONFIG     = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_PRIO_SEL   = 8'h18;
  localparam logic [7:0] OFS_PRIO_DATA  = 8'h1C;
  localparam logic [7:0] OFS_PEND_LO    = 8'h20;
  localparam logic [7:0] OFS_PEND_HI    = 8'h24;

  // Field positions
  localparam int unsigned LINE_CNT_W       = 5;
  localparam int unsigned BIT_SYS_RESET    = 2;
  localparam int unsigned BIT_SLEEP_EXIT   = 1;
  localparam int unsigned BIT_DEEP_SLEEP   = 2;
  localparam int unsigned BIT_ST_SLEEP     = 0;
  localparam int unsigned BIT_ST_LOCKED    = 1;
  localparam int unsigned BIT_ST_EXCL      = 2;

  localparam logic [4:0]  LINE_CNT_VALUE = 5'h00;
  localparam logic [31:0] AUX_FAULT_VALUE = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
  localparam logic [7:0]  PRIO_MASK      = 8'hE0;
  localparam logic [2:0]  PRIO_RESET     = 3'h0;

  // Register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Core side status
  typedef struct packed {
    logic wait_interrupt_instr;
    logic isr_exit;
    logic nmi;
    logic fault_unrecoverable;
    logic excl_access;
  } core_evt_t;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_SLEEP  = 3'b010,
    ST_LOCKED = 3'b100
  } core_state_t;
endpackage

/* hw/exc_prio_store.sv */
// Per-interrupt priority storage with only the top bits implemented
`timescale 1ns/1ns
module exc_prio_store #(
  parameter int unsigned N = 60,
  parameter int unsigned W = 3
) (
  input  wire logic         clk_sys_in,
  input  wire logic         rst_b_in,
  input  wire logic         wr_in,
  input  wire logic [5:0]   idx_in,
  input  wire logic [W-1:0] wdata_in,
  input  wire logic [5:0]   rd_idx_in,
  output logic      [W-1:0] rdata_out
);
  import exc_pkg::*;

  logic [W-1:0] prio_reg  [N];
  logic [W-1:0] prio_next [N];

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_prio
      always_comb
      begin
        prio_next[g] = prio_reg[g];
        if (wr_in && (idx_in == 6'(g)))
        begin
          prio_next[g] = wdata_in;
        end
      end
      always_ff @(posedge clk_sys_in)
      begin
        if (!rst_b_in)
        begin
          prio_reg[g] <= W'(0);
        end
        else
        begin
          prio_reg[g] <= prio_next[g];
        end
      end
    end
  endgenerate

  // Out-of-range index reads as zero
  assign rdata_out = (int'(rd_idx_in) < N) ? prio_reg[rd_idx_in] : W'(0);
endmodule

/* hw/exc_reset_gen.sv */
// System reset request pulse stretcher
`timescale 1ns/1ns
module exc_reset_gen #(
  parameter int unsigned HOLD = 4
) (
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  input  wire logic req_in,
  output logic      sys_reset_out
);
  import exc_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (req_in)
    begin
      cnt_next = 4'(HOLD);
    end
    else if (cnt_reg != 4'h0)
    begin
      cnt_next = cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      cnt_reg <= 4'h0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  assign sys_reset_out = (cnt_reg != 4'h0);
endmodule
